// ### design/pg_mon_pkg.sv
package pg_mon_pkg;

  // Rail indices: 0 master buck, 1 second buck, 2 and 3 linear regulators
  localparam int NUM_BUCK = 2;
  localparam int NUM_LIN = 2;
  localparam int NUM_RAIL = NUM_BUCK + NUM_LIN;
  localparam int SLAVE_BUCK_IDX = 1;
  localparam int ILIM_W = 3;

  // Timing
  localparam int CLK_MHZ = 100;
  localparam int HOLD_TIME_US = 800;
  localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
  localparam int CLIM_TIME_US = 20;
  localparam int CLIM_CYCLES = CLIM_TIME_US * CLK_MHZ;

  // Register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] FAULT_ADDR = 8'h04;
  localparam logic [7:0] IRQ_ADDR = 8'h08;
  localparam logic [7:0] MASK_ADDR = 8'h0c;
  localparam logic [7:0] STATUS_ADDR = 8'h10;
  localparam logic [7:0] ILIM_ADDR = 8'h14;

  // Interrupt register field positions
  localparam int IRQ_BUCK_LSB = 0;
  localparam int IRQ_LIN_LSB = 2;
  localparam int IRQ_OV_BIT = 4;
  localparam int IRQ_TSD_BIT = 5;

  // Status register field positions
  localparam int ST_PG_BIT = 0;
  localparam int ST_BUCK_LSB = 1;
  localparam int ST_LIN_LSB = 3;
  localparam int ST_TWARN_BIT = 5;
  localparam int ST_OV_BIT = 6;
  localparam int ST_TSD_BIT = 7;

  typedef struct packed {
    logic fault_holds_pg_inactive;
    logic pg_gated_or_continuous;
    logic pg_open_drain;
    logic pg_polarity;
    logic thermal_warn_pg_sel;
    logic [NUM_RAIL-1:0] pg_window_sel;
    logic [NUM_RAIL-1:0] pg_monitor_sel;
  } pg_ctrl_t;

  localparam int CTRL_W = $bits(pg_ctrl_t);
  localparam pg_ctrl_t CTRL_RESET = '{
    fault_holds_pg_inactive: 1'b0,
    pg_gated_or_continuous: 1'b0,
    pg_open_drain: 1'b0,
    pg_polarity: 1'b1,
    thermal_warn_pg_sel: 1'b0,
    pg_window_sel: 4'h0,
    pg_monitor_sel: 4'hf
  };
  localparam logic [NUM_BUCK*ILIM_W-1:0] ILIM_RESET = 6'h00;

  // Pin inputs, all asynchronous to mclk_i
  typedef struct packed {
    logic [NUM_RAIL-1:0] rail_enable;
    logic [NUM_RAIL-1:0] rail_uv_ok;
    logic [NUM_RAIL-1:0] rail_ov_ok;
    logic [NUM_RAIL-1:0] rail_ramping;
    logic [NUM_BUCK-1:0] buck_peak;
    logic [NUM_LIN-1:0] linreg_limit;
    logic dual_phase;
    logic thermal_warn_status;
    logic overvoltage;
    logic thermal_shutdown;
    logic otp_done;
    logic otp_pg_mode;
  } pin_in_t;

endpackage

// ### design/pg_monitor.sv
`timescale 1ns/100ps
// Notes on behaviour
// R01: Per-rail enable selects monitor; slave buck excluded dual-phase
// R02: Disabled rails never drag power good down
// R03: Optional thermal warning source for power good
// R04: Power good needs all sources valid, no overvoltage or shutdown irqs
// R05: Window bit chooses undervoltage or both checks
// R06: Pin polarity and push-pull/open-drain selectable
// R07: Mode bit from OTP: gated or continuous
// R08: Gated mode starts active after OTP load
// R09: Gated mode holds 800 us after enable/change
// R10: Gated faults latch and stop monitoring until cleared
// R11: Host clears faults and irqs writing one
// R12: Continuous mode active after load, drops on enable
// R13: Continuous mode tracks regulation without hold-off
// R14: Fault bits latch until written with one
// R15: Continuous mode inactive while rail voltage transitions
// R16: Recovered rail restores power good unless fault-gated
// R17: Fault gating keeps power good low while pending
// R18: Buck 20 us peak regulation sets irq, pin low
// R19: Live buck limit status; write one clears irq
// R20: Linear 20 us limit sets irq, status, clear
// R21: Mask bit suppresses current-limit irq from pin
// R22: Host programs identical buck limit fields per rail
// R23: Polarity inverts only the external pin
// R24: Hold and qualify timers restart on their trigger
module pg_monitor
  import pg_mon_pkg::*;
#(
  parameter int HOLD_COUNT = HOLD_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Analog and sequencer indications
  input wire logic [NUM_RAIL-1:0] rail_enable_i,
  input wire logic [NUM_RAIL-1:0] rail_uv_ok_i,
  input wire logic [NUM_RAIL-1:0] rail_ov_ok_i,
  input wire logic [NUM_RAIL-1:0] rail_ramping_i,
  input wire logic [NUM_BUCK-1:0] buck_peak_i,
  input wire logic [NUM_LIN-1:0] linreg_limit_i,
  input wire logic dual_phase_i,
  input wire logic thermal_warn_status_i,
  input wire logic overvoltage_i,
  input wire logic thermal_shutdown_i,
  input wire logic otp_done_i,
  input wire logic otp_pg_mode_i,
  // Pins and regulator settings
  output logic power_good_out_o,
  output logic power_good_oe_n_o,
  output logic irq_out_n_o,
  output logic [NUM_BUCK*ILIM_W-1:0] buck_current_limit_sel_o
);

  localparam int HOLD_W = $clog2(HOLD_COUNT + 1);
  localparam int CLIM_W = $clog2(CLIM_CYCLES + 1);
  localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_COUNT);
  localparam logic [CLIM_W-1:0] CLIM_LAST = CLIM_W'(CLIM_CYCLES - 1);
  localparam logic [CLIM_W-1:0] CLIM_DONE = CLIM_W'(CLIM_CYCLES);
  localparam int NUM_CL = NUM_BUCK + NUM_LIN;

  if (HOLD_COUNT < 1) begin : g_bad_hold
    $error("HOLD_COUNT must be at least one");
  end
  if (NUM_RAIL != 4 || NUM_BUCK != 2) begin : g_bad_rails
    $error("Register layout serves two bucks and two linear regulators");
  end

  function automatic logic [31:0] w1c_mask(input logic [31:0] wdata, input logic hit);
    w1c_mask = hit ? wdata : 32'h0000_0000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  pin_in_t pin_raw;
  pin_in_t pin_meta_reg;
  pin_in_t pin_reg;

  assign pin_raw = '{
    rail_enable: rail_enable_i,
    rail_uv_ok: rail_uv_ok_i,
    rail_ov_ok: rail_ov_ok_i,
    rail_ramping: rail_ramping_i,
    buck_peak: buck_peak_i,
    linreg_limit: linreg_limit_i,
    dual_phase: dual_phase_i,
    thermal_warn_status: thermal_warn_status_i,
    overvoltage: overvoltage_i,
    thermal_shutdown: thermal_shutdown_i,
    otp_done: otp_done_i,
    otp_pg_mode: otp_pg_mode_i
  };

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pin_meta_reg <= '0;
      pin_reg <= '0;
    end else begin
      pin_meta_reg <= pin_raw;
      pin_reg <= pin_meta_reg;
    end
  end

  // Previous synced values for edge detection
  logic [NUM_RAIL-1:0] en_d_reg;
  logic [NUM_RAIL-1:0] ramp_d_reg;
  logic otp_done_d_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      en_d_reg <= '0;
      ramp_d_reg <= '0;
      otp_done_d_reg <= 1'b0;
    end else begin
      en_d_reg <= pin_reg.rail_enable;
      ramp_d_reg <= pin_reg.rail_ramping;
      otp_done_d_reg <= pin_reg.otp_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, zero wait states
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic mapped;
  logic wr_ctrl, wr_fault, wr_irq, wr_mask, wr_ilim;
  logic [31:0] rd_value;

  assign addr_phase = hsel_i && htrans_i[1] && hready_i;
  assign mapped = (haddr_i[31:5] == 27'h0) && (haddr_i[1:0] == 2'h0);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_phase && hwrite_i && mapped;
      wr_addr_reg <= haddr_i[7:0];
    end
  end

  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == CTRL_ADDR);
  assign wr_fault = wr_pend_reg && (wr_addr_reg == FAULT_ADDR);
  assign wr_irq = wr_pend_reg && (wr_addr_reg == IRQ_ADDR);
  assign wr_mask = wr_pend_reg && (wr_addr_reg == MASK_ADDR);
  assign wr_ilim = wr_pend_reg && (wr_addr_reg == ILIM_ADDR);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      hrdata_o <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      if (addr_phase && !hwrite_i) begin
        hrdata_o <= mapped ? rd_value : 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  pg_ctrl_t ctrl_reg;
  logic [NUM_CL-1:0] climit_mask_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= pg_ctrl_t'(hwdata_i[CTRL_W-1:0]);
      end
      if (pin_reg.otp_done && !otp_done_d_reg) begin
        ctrl_reg.pg_gated_or_continuous <= pin_reg.otp_pg_mode; // [R07]
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      climit_mask_reg <= '0;
      buck_current_limit_sel_o <= ILIM_RESET;
    end else begin
      if (wr_mask) begin
        climit_mask_reg <= hwdata_i[NUM_CL-1:0];
      end
      if (wr_ilim) begin
        buck_current_limit_sel_o <= hwdata_i[NUM_BUCK*ILIM_W-1:0]; // [R22]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rail evaluation and gated-mode hold timers
  logic continuous;
  logic [NUM_RAIL-1:0] sel_eff;
  logic [NUM_RAIL-1:0] consider;
  logic [NUM_RAIL-1:0] rail_ok;
  logic [NUM_RAIL-1:0] hold_busy;
  logic [NUM_RAIL-1:0] hold_start;
  logic [NUM_RAIL-1:0] fault_set;
  logic [HOLD_W-1:0] hold_cnt_reg [NUM_RAIL];

  assign continuous = ctrl_reg.pg_gated_or_continuous;

  always_comb begin
    sel_eff = ctrl_reg.pg_monitor_sel;
    if (pin_reg.dual_phase) begin
      sel_eff[SLAVE_BUCK_IDX] = 1'b0; // [R01]
    end
  end

  assign consider = sel_eff & pin_reg.rail_enable; // [R01] [R02]
  assign rail_ok = pin_reg.rail_uv_ok & (~ctrl_reg.pg_window_sel | pin_reg.rail_ov_ok); // [R05]

  // Trigger cycle counts as held, else a fault latches before the load
  assign hold_start = (pin_reg.rail_enable & ~en_d_reg) | (pin_reg.rail_ramping & ~ramp_d_reg);

  for (genvar i = 0; i < NUM_RAIL; i++) begin : g_hold
    always_ff @(posedge mclk_i) begin
      if (reset_i) begin
        hold_cnt_reg[i] <= '0;
      end else if (hold_start[i]) begin
        hold_cnt_reg[i] <= HOLD_LOAD; // [R09] [R24]
      end else if (hold_cnt_reg[i] != '0) begin
        hold_cnt_reg[i] <= hold_cnt_reg[i] - HOLD_W'(1);
      end
    end
    assign hold_busy[i] = hold_start[i] || (hold_cnt_reg[i] != '0); // [R09]
  end

  // Gated mode waits out the hold; continuous latches any settled bad rail
  assign fault_set = continuous ? (consider & ~rail_ok & ~pin_reg.rail_ramping) // [R13]
                                : (consider & ~rail_ok & ~hold_busy); // [R09] [R10]

  ////////////////////////////////////////////////////////////////////////////
  // Fault latch and interrupt flags, set wins over clear
  logic [NUM_RAIL-1:0] rail_fault_latch_reg;
  logic overvoltage_irq_reg;
  logic thermal_shutdown_irq_reg;
  logic [NUM_CL-1:0] climit_irq_reg;
  logic [NUM_CL-1:0] climit_live;
  logic [NUM_CL-1:0] climit_set;
  logic [CLIM_W-1:0] climit_cnt_reg [NUM_CL];
  logic [31:0] fault_clr;
  logic [31:0] irq_clr;

  assign fault_clr = w1c_mask(hwdata_i, wr_fault);
  assign irq_clr = w1c_mask(hwdata_i, wr_irq);
  assign climit_live = {pin_reg.linreg_limit, pin_reg.buck_peak};

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rail_fault_latch_reg <= '0;
    end else begin
      rail_fault_latch_reg <= (rail_fault_latch_reg & ~fault_clr[NUM_RAIL-1:0]) | fault_set; // [R11] [R14]
    end
  end

  // Level still present re-sets the flag, so a clear during it fails
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      overvoltage_irq_reg <= 1'b0;
      thermal_shutdown_irq_reg <= 1'b0;
    end else begin
      overvoltage_irq_reg <= (overvoltage_irq_reg && !irq_clr[IRQ_OV_BIT]) || pin_reg.overvoltage; // [R11]
      thermal_shutdown_irq_reg <= (thermal_shutdown_irq_reg && !irq_clr[IRQ_TSD_BIT]) ||
                                  pin_reg.thermal_shutdown; // [R11]
    end
  end

  for (genvar k = 0; k < NUM_CL; k++) begin : g_climit
    always_ff @(posedge mclk_i) begin
      if (reset_i || !climit_live[k]) begin
        climit_cnt_reg[k] <= '0; // [R24]
      end else if (climit_cnt_reg[k] != CLIM_DONE) begin
        climit_cnt_reg[k] <= climit_cnt_reg[k] + CLIM_W'(1);
      end
    end
    assign climit_set[k] = climit_live[k] && (climit_cnt_reg[k] == CLIM_LAST); // [R18] [R20]
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      climit_irq_reg <= '0;
    end else begin
      climit_irq_reg <= (climit_irq_reg & ~irq_clr[NUM_CL-1:0]) | climit_set; // [R19] [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power good combination
  logic otp_loaded_reg;
  logic pg_status_reg;
  logic pg_next;
  logic common_ok;
  logic rails_ok_now;
  logic pin_level;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      otp_loaded_reg <= 1'b0;
    end else if (pin_reg.otp_done) begin
      otp_loaded_reg <= 1'b1;
    end
  end

  assign common_ok = !(ctrl_reg.thermal_warn_pg_sel && pin_reg.thermal_warn_status) && // [R03]
                     !overvoltage_irq_reg && !thermal_shutdown_irq_reg; // [R04]
  assign rails_ok_now = &(~consider | (rail_ok & ~pin_reg.rail_ramping)); // [R12] [R15]

  always_comb begin
    if (!otp_loaded_reg) begin
      pg_next = 1'b1; // [R08] [R12]
    end else if (continuous) begin
      pg_next = common_ok && rails_ok_now && // [R04] [R13] [R16]
                !(ctrl_reg.fault_holds_pg_inactive && (|rail_fault_latch_reg)); // [R17]
    end else begin
      // Gated mode resumes only after every latched fault is cleared
      pg_next = common_ok && !(|rail_fault_latch_reg); // [R10]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pg_status_reg <= 1'b1;
    end else begin
      pg_status_reg <= pg_next;
    end
  end

  assign pin_level = pg_next ? ctrl_reg.pg_polarity : !ctrl_reg.pg_polarity; // [R23]

  // Open drain only pulls low; push-pull drives both levels
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      power_good_out_o <= 1'b1;
      power_good_oe_n_o <= 1'b0;
    end else begin
      power_good_out_o <= ctrl_reg.pg_open_drain ? 1'b0 : pin_level; // [R06]
      power_good_oe_n_o <= ctrl_reg.pg_open_drain ? pin_level : 1'b0; // [R06]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_out_n_o <= 1'b1;
    end else begin
      irq_out_n_o <= !((|(climit_irq_reg & ~climit_mask_reg)) || // [R21]
                       overvoltage_irq_reg || thermal_shutdown_irq_reg); // [R18] [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    case (haddr_i[7:0])
      CTRL_ADDR: rd_value[CTRL_W-1:0] = ctrl_reg;
      FAULT_ADDR: rd_value[NUM_RAIL-1:0] = rail_fault_latch_reg;
      IRQ_ADDR: begin
        rd_value[IRQ_BUCK_LSB +: NUM_BUCK] = climit_irq_reg[NUM_BUCK-1:0];
        rd_value[IRQ_LIN_LSB +: NUM_LIN] = climit_irq_reg[NUM_CL-1:NUM_BUCK];
        rd_value[IRQ_OV_BIT] = overvoltage_irq_reg;
        rd_value[IRQ_TSD_BIT] = thermal_shutdown_irq_reg;
      end
      MASK_ADDR: rd_value[NUM_CL-1:0] = climit_mask_reg;
      STATUS_ADDR: begin
        rd_value[ST_PG_BIT] = pg_status_reg; // [R23]
        rd_value[ST_BUCK_LSB +: NUM_BUCK] = pin_reg.buck_peak; // [R19]
        rd_value[ST_LIN_LSB +: NUM_LIN] = pin_reg.linreg_limit; // [R20]
        rd_value[ST_TWARN_BIT] = pin_reg.thermal_warn_status;
        rd_value[ST_OV_BIT] = pin_reg.overvoltage;
        rd_value[ST_TSD_BIT] = pin_reg.thermal_shutdown;
      end
      ILIM_ADDR: rd_value[NUM_BUCK*ILIM_W-1:0] = buck_current_limit_sel_o;
      default: rd_value = 32'h0000_0000;
    endcase
  end

endmodule // pg_monitor

// ### verification/host_pins_model.sv
`timescale 1ns/100ps
module host_pins_model (
  // Device pins
  input wire logic pg_data_i,
  input wire logic pg_oe_n_i,
  input wire logic irq_n_i,
  // Levels seen by the host
  output logic pg_level_o,
  output logic irq_level_n_o
);
  // Board pull-up: a released pin reads high
  assign pg_level_o = pg_oe_n_i ? 1'b1 : pg_data_i;
  assign irq_level_n_o = irq_n_i;
endmodule // host_pins_model

// ### verification/pg_monitor_props.sv
`timescale 1ns/100ps
module pg_monitor_props
  import pg_mon_pkg::*;
(
  // Clock, reset and bus
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  // Indications and pins
  input wire logic [NUM_BUCK-1:0] buck_peak_i,
  input wire logic [NUM_LIN-1:0] linreg_limit_i,
  input wire logic overvoltage_i,
  input wire logic thermal_shutdown_i,
  input wire logic power_good_out_o,
  input wire logic power_good_oe_n_o,
  input wire logic irq_out_n_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  int buck_run;
  int lin_run;
  ////////////////////////////////////////////////////////////
  // Saturating run lengths, capped to keep the counters small
  always_ff @(posedge mclk_i) begin
    buck_run <= buck_peak_i[0] ? ((buck_run < 4000) ? buck_run + 1 : buck_run) : 0;
  end
  always_ff @(posedge mclk_i) begin
    lin_run <= linreg_limit_i[0] ? ((lin_run < 4000) ? lin_run + 1 : lin_run) : 0;
  end
  sequence rd_at(logic [7:0] a);
    hsel_i && htrans_i[1] && hready_i && !hwrite_i && haddr_i == {24'h000000, a};
  endsequence
  ////////////////////////////////////////////////////////////
  a_od_release_low: assert property (power_good_oe_n_o |-> !power_good_out_o)
    else $error("released pin not low");
  a_ov_irq_pin: assert property (overvoltage_i [*3] |-> ##[1:4] !irq_out_n_o)
    else $error("overvoltage left irq pin high");
  a_tsd_irq_pin: assert property (thermal_shutdown_i [*3] |-> ##[1:4] !irq_out_n_o)
    else $error("shutdown left irq pin high");
  a_ov_blocks_pg: assert property (overvoltage_i [*6] ##0 rd_at(STATUS_ADDR) |=>
    hrdata_o[ST_OV_BIT] && !hrdata_o[ST_PG_BIT])
    else $error("power good with overvoltage");
  a_buck_live_status: assert property ($stable(buck_peak_i) [*4] ##0 rd_at(STATUS_ADDR) |=>
    hrdata_o[ST_BUCK_LSB +: NUM_BUCK] == $past(buck_peak_i))
    else $error("buck status not live");
  a_lin_live_status: assert property ($stable(linreg_limit_i) [*4] ##0 rd_at(STATUS_ADDR) |=>
    hrdata_o[ST_LIN_LSB +: NUM_LIN] == $past(linreg_limit_i))
    else $error("linear status not live");
  a_buck_irq_sets: assert property (rd_at(IRQ_ADDR) ##0 (buck_run inside {[2006:2200]}) |=>
    hrdata_o[IRQ_BUCK_LSB])
    else $error("buck limit irq missing");
  a_lin_irq_sets: assert property (rd_at(IRQ_ADDR) ##0 (lin_run inside {[2006:2200]}) |=>
    hrdata_o[IRQ_LIN_LSB])
    else $error("linear limit irq missing");
endmodule // pg_monitor_props

bind pg_monitor pg_monitor_props u_pg_monitor_props (
  .mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .buck_peak_i, .linreg_limit_i, .overvoltage_i, .thermal_shutdown_i,
  .power_good_out_o, .power_good_oe_n_o, .irq_out_n_o
);

// ### verification/test_pg_monitor.sv
`timescale 1ns/100ps
module test_pg_monitor
  import pg_mon_pkg::*;
;
  logic mclk_i;
  logic reset_i;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  logic power_good_out_o;
  logic power_good_oe_n_o;
  logic irq_out_n_o;
  logic [NUM_BUCK*ILIM_W-1:0] ilim;
  logic pg_wire;
  logic irq_wire;
  pin_in_t pin;
  int num_errors;
  int samples_checked;
  ////////////////////////////////////////////////////////////
  // Short hold count keeps the gated runs brief
  pg_monitor #(.HOLD_COUNT(20)) u_pg_monitor (
    .mclk_i, .reset_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .rail_enable_i(pin.rail_enable), .rail_uv_ok_i(pin.rail_uv_ok), .rail_ov_ok_i(pin.rail_ov_ok),
    .rail_ramping_i(pin.rail_ramping), .buck_peak_i(pin.buck_peak), .linreg_limit_i(pin.linreg_limit),
    .dual_phase_i(pin.dual_phase), .thermal_warn_status_i(pin.thermal_warn_status),
    .overvoltage_i(pin.overvoltage), .thermal_shutdown_i(pin.thermal_shutdown),
    .otp_done_i(pin.otp_done), .otp_pg_mode_i(pin.otp_pg_mode),
    .power_good_out_o, .power_good_oe_n_o, .irq_out_n_o, .buck_current_limit_sel_o(ilim)
  );
  host_pins_model u_host_pins_model (
    .pg_data_i(power_good_out_o), .pg_oe_n_i(power_good_oe_n_o), .irq_n_i(irq_out_n_o),
    .pg_level_o(pg_wire), .irq_level_n_o(irq_wire)
  );
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic ticks(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      num_errors++;
      complete_run();
    end
  endtask
  // Address phase held until ready, then data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    q = hrdata_o;
    chk("hresp", {31'h0, hresp_o}, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 1'b0, 32'h0, q);
    chk($sformatf("reg %h", a), q, e);
  endtask
  // Pins are looked at off the edge, after they settle
  task automatic pins(input logic pg_e, input logic irq_e);
    ticks(6);
    #1;
    chk("pg pin", {31'h0, pg_wire}, {31'h0, pg_e});
    chk("irq pin", {31'h0, irq_wire}, {31'h0, irq_e});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pin = '0;
    pin.rail_uv_ok = 4'h8;
    pin.rail_ov_ok = 4'hf;
    num_errors = 0;
    samples_checked = 0;
    ticks(12);
    reset_i <= 1'b0;
    rdc(CTRL_ADDR, 32'h20f);
    rdc(8'h18, 32'h0);
    @(posedge mclk_i) pin.otp_done <= 1'b1;
    pins(1'b1, 1'b1);
    $display("Test reset finished");
    @(posedge mclk_i) pin.dual_phase <= 1'b1;
    @(posedge mclk_i) pin.rail_enable <= 4'h3;
    ticks(4);
    pins(1'b1, 1'b1);
    ticks(20);
    pins(1'b0, 1'b1);
    rdc(FAULT_ADDR, 32'h1);
    @(posedge mclk_i) pin.rail_uv_ok <= 4'h9;
    pins(1'b0, 1'b1);
    wr(FAULT_ADDR, 32'hf);
    pins(1'b1, 1'b1);
    rdc(FAULT_ADDR, 32'h0);
    $display("Test gated finished");
    wr(CTRL_ADDR, 32'ha0f);
    pins(1'b1, 1'b1);
    @(posedge mclk_i) pin.rail_enable <= 4'h7;
    pins(1'b0, 1'b1);
    @(posedge mclk_i) pin.rail_uv_ok <= 4'hd;
    pins(1'b1, 1'b1);
    rdc(FAULT_ADDR, 32'h4);
    wr(CTRL_ADDR, 32'h1a0f);
    pins(1'b0, 1'b1);
    wr(FAULT_ADDR, 32'hf);
    pins(1'b1, 1'b1);
    @(posedge mclk_i) pin.rail_ramping <= 4'h1;
    pins(1'b0, 1'b1);
    @(posedge mclk_i) pin.rail_ramping <= 4'h0;
    pins(1'b1, 1'b1);
    @(posedge mclk_i) pin.rail_ov_ok <= 4'he;
    pins(1'b1, 1'b1);
    wr(CTRL_ADDR, 32'h1a1f);
    pins(1'b0, 1'b1);
    @(posedge mclk_i) pin.rail_ov_ok <= 4'hf;
    pins(1'b0, 1'b1);
    wr(FAULT_ADDR, 32'hf);
    @(posedge mclk_i) pin.thermal_warn_status <= 1'b1;
    pins(1'b1, 1'b1);
    wr(CTRL_ADDR, 32'hb0f);
    pins(1'b0, 1'b1);
    rdc(STATUS_ADDR, 32'h20);
    @(posedge mclk_i) pin.thermal_warn_status <= 1'b0;
    wr(CTRL_ADDR, 32'h80f);
    pins(1'b0, 1'b1);
    rdc(STATUS_ADDR, 32'h1);
    wr(CTRL_ADDR, 32'he0f);
    pins(1'b1, 1'b1);
    chk("pg enable", {31'h0, power_good_oe_n_o}, 32'h1);
    @(posedge mclk_i) pin.rail_uv_ok <= 4'hc;
    pins(1'b0, 1'b1);
    @(posedge mclk_i) pin.rail_uv_ok <= 4'hd;
    wr(FAULT_ADDR, 32'hf);
    pins(1'b1, 1'b1);
    $display("Test continuous finished");
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_i) {pin.thermal_shutdown, pin.overvoltage} <= 2'(i + 1);
      ticks(6);
      rdc(STATUS_ADDR, 32'h40 << i);
      @(posedge mclk_i) {pin.thermal_shutdown, pin.overvoltage} <= 2'b00;
      pins(1'b0, 1'b0);
      rdc(IRQ_ADDR, 32'h10 << i);
      wr(IRQ_ADDR, 32'h30);
      pins(1'b1, 1'b1);
    end
    $display("Test protection finished");
    wr(MASK_ADDR, 32'h1);
    rdc(MASK_ADDR, 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i) {pin.linreg_limit, pin.buck_peak} <= 4'(1 << i);
      ticks(1990);
      pins(1'b1, 1'b1);
      ticks(10);
      pins(1'b1, i == 0);
      rdc(IRQ_ADDR, 32'(1 << i));
      rdc(STATUS_ADDR, 32'(2 << i) | 32'h1);
      @(posedge mclk_i) {pin.linreg_limit, pin.buck_peak} <= 4'h0;
      wr(IRQ_ADDR, 32'hf);
      pins(1'b1, 1'b1);
      rdc(IRQ_ADDR, 32'h0);
    end
    // Both bucks share one rail, so the fields match
    wr(ILIM_ADDR, 32'h2d);
    ticks(2);
    chk("ilim out", 32'(ilim), 32'h2d);
    rdc(ILIM_ADDR, 32'h2d);
    $display("Test current limit finished");
    // Mid-run reset with the mode pin high: mode reloads on the synced load edge
    @(posedge mclk_i) pin.otp_pg_mode <= 1'b1;
    reset_i <= 1'b1;
    ticks(2);
    #1;
    chk("pg enable", {31'h0, power_good_oe_n_o}, 32'h0);
    @(posedge mclk_i) reset_i <= 1'b0;
    ticks(4);
    rdc(CTRL_ADDR, 32'ha0f);
    rdc(ILIM_ADDR, 32'h0);
    pins(1'b1, 1'b1);
    $display("Test mode load finished");
    complete_run();
  end
endmodule // test_pg_monitor
